// ---- exec_exception_status_consts.vh ----
// Function
// - Bits 26:25 and 15:10 hold either continuation or conditional-block state
// - Continuation state keeps bits 26:25 at zero
// - Continuation state keeps bits 11:10 at zero
// - Conditional block covers at most four instructions after one opener
// - Block conditions are all equal or some are the inverse
// - Interrupted multiple transfer records next register in bits 15:12
// - Resumed transfer continues from the register in bits 15:12
// - Instruction-set state bit at bit 24, resets to one
// - Exchange branches and pop to counter update the state bit
// - Exception return reloads the state bit from stacked word
// - Exception entry loads state bit from vector bit 0; reset loads one
// - Executing with state bit clear raises a fault
// - Reserved bits 23:16 and 9:6 read as zero
// - Bits 5:0 report active exception number, read-only
// - Execution fields read as zero in every software read view
// - Exception number meaningful only in full or exception view
// - Saturation flag cleared only by reset or explicit software write
// - Saturation flag at bit 27 sets on overflow, stays set
// - Execution view reads zero, writes ignored
// - Writes to exception number bits are ignored
`ifndef EXEC_EXCEPTION_STATUS_CONSTS_VH
`define EXEC_EXCEPTION_STATUS_CONSTS_VH

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SAT_BIT 27
`define CB_HI_MSB 26
`define CB_HI_LSB 25
`define ISET_BIT 24
`define CB_LO_MSB 15
`define CB_LO_LSB 10
`define EXC_MSB 5
`define EXC_LSB 0

// ----------------------------------------------------------------
// Reset values and exception numbers
// ----------------------------------------------------------------
`define ISET_RESET 1'B1
`define PSW_RESET 32'H0100_0000
`define EXC_THREAD 6'H00
`define EXC_EXT_BASE 6'H10
`define EXC_EXT_LAST 6'H3B
`define EXT_VEC_MAX 6'H2B

// ----------------------------------------------------------------
// Access views
// ----------------------------------------------------------------
`define VIEW_FLAGS 2'H0
`define VIEW_FULL 2'H1
`define VIEW_EXEC 2'H2
`define VIEW_EXC 2'H3

`endif

// ---- exc_num_check.v ----
`timescale 1ns/1ps
`include "exec_exception_status_consts.vh"
module exc_num_check
(
    input wire [5:0] num,
    output reg valid
);
    always @*
    begin
        case (num)
            6'H00, 6'H02, 6'H03, 6'H04, 6'H05, 6'H06, 6'H0B, 6'H0E, 6'H0F:
                valid = 1'B1;
            default:
                valid = (num >= `EXC_EXT_BASE) && (num <= `EXC_EXT_LAST);
        endcase
    end
endmodule

// ---- exec_exception_status.v ----
`timescale 1ns/1ps
`include "exec_exception_status_consts.vh"
module exec_exception_status
(
    input wire ref_clk,
    input wire nrst,
    input wire sat_event,
    input wire sw_write,
    input wire [1:0] sw_write_view,
    input wire [31:0] sw_write_data,
    input wire [1:0] sw_read_view,
    input wire exc_entry,
    input wire [5:0] exc_entry_num,
    input wire [31:0] vector_value,
    input wire exc_return,
    input wire [31:0] stacked_status_word,
    input wire branch_exchange,
    input wire branch_link_exchange,
    input wire pop_to_program_counter,
    input wire [31:0] branch_target,
    input wire cb_start,
    input wire [7:0] cb_init,
    input wire cb_advance,
    input wire mt_interrupt,
    input wire [3:0] mt_next_reg,
    input wire mt_resume,
    input wire instr_issue,
    output reg [31:0] program_status_word,
    output reg [31:0] sw_read_data,
    output reg [3:0] mt_resume_reg,
    output reg mt_resume_valid,
    output reg iset_fault
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    localparam ST_IDLE = 3'B001;
    localparam ST_BLOCK = 3'B010;
    localparam ST_CONT = 3'B100;

    reg [2:0] st_q;
    reg [2:0] st_d;
    reg [7:0] cb_q;
    reg [7:0] cb_d;
    reg [3:0] cont_q;
    reg [3:0] cont_d;
    reg iset_q;
    reg iset_d;
    reg sat_q;
    reg [5:0] exc_q;
    reg [5:0] exc_d;
    wire entry_ok;
    wire ret_ok;
    wire [7:0] cb_stacked;
    wire [7:0] cb_next;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Mask shifts left, shared condition stays; low three bits zero ends it
    function [7:0] cb_step;
        input [7:0] cb;
        begin
            if (cb[2:0] == 3'H0)
                cb_step = 8'H00;
            else
                cb_step = {cb[7:5], cb[3:0], 1'H0};
        end
    endfunction

    // Only the flags and full views carry bit 27 on a write
    function view_writes_flags;
        input [1:0] view;
        begin
            view_writes_flags = (view == `VIEW_FLAGS) || (view == `VIEW_FULL);
        end
    endfunction

    // Exception number shows in the full and exception views only
    function view_reads_exc;
        input [1:0] view;
        begin
            view_reads_exc = (view == `VIEW_FULL) || (view == `VIEW_EXC);
        end
    endfunction

    // Exec view hides the whole word, flag included
    function view_reads_sat;
        input [1:0] view;
        begin
            view_reads_sat = (view != `VIEW_EXEC);
        end
    endfunction

    // Nonzero with an empty mask nibble, so 11:10 and 26:25 are zero
    function is_cont_field;
        input [7:0] fld;
        begin
            is_cont_field = (fld != 8'H00) && (fld[3:0] == 4'H0);
        end
    endfunction

    assign cb_stacked = {stacked_status_word[`CB_LO_MSB:`CB_LO_LSB],
                         stacked_status_word[`CB_HI_MSB:`CB_HI_LSB]};
    assign cb_next = cb_step(cb_q);

    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------
    wire sat_clear;
    wire branch_any;
    wire ret_to_cont;
    wire ret_to_block;

    // Reset or writing a zero are the only ways back; exec and exception views cannot
    assign sat_clear = sw_write && view_writes_flags(sw_write_view)
                       && !sw_write_data[`SAT_BIT];
    assign branch_any = branch_exchange || branch_link_exchange
                        || pop_to_program_counter;
    // A nonzero stacked field with empty mask nibble can only be a continuation
    assign ret_to_cont = is_cont_field(cb_stacked);
    assign ret_to_block = (cb_stacked[3:0] != 4'H0);

    exc_num_check u_entry_check
    (
        .num(exc_entry_num),
        .valid(entry_ok)
    );

    exc_num_check u_ret_check
    (
        .num(stacked_status_word[`EXC_MSB:`EXC_LSB]),
        .valid(ret_ok)
    );

    // ----------------------------------------------------------------
    // Combined field view
    // ----------------------------------------------------------------
    function [7:0] pack_field;
        input [2:0] st;
        input [7:0] cb;
        input [3:0] cont;
        begin
            // Layout {15:10, 26:25}; continuation zeroes 11:10 and 26:25
            if (st == ST_CONT)
                pack_field = {cont, 4'H0};
            else if (st == ST_BLOCK)
                pack_field = cb;
            else
                pack_field = 8'H00;
        end
    endfunction

    function [31:0] build_word;
        input sat;
        input iset;
        input [7:0] fld;
        input [5:0] exc;
        begin
            build_word = 32'H0000_0000;
            build_word[`SAT_BIT] = sat;
            build_word[`ISET_BIT] = iset;
            build_word[`CB_HI_MSB:`CB_HI_LSB] = fld[1:0];
            build_word[`CB_LO_MSB:`CB_LO_LSB] = fld[7:2];
            build_word[`EXC_MSB:`EXC_LSB] = exc;
        end
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always @*
    begin
        st_d = st_q;
        cb_d = cb_q;
        cont_d = cont_q;
        iset_d = iset_q;
        exc_d = exc_q;
        // Software writes never reach these fields
        if (exc_entry)
        begin
            iset_d = vector_value[0];
            if (entry_ok)
                exc_d = exc_entry_num;
            if (mt_interrupt)
            begin
                st_d = ST_CONT;
                cont_d = mt_next_reg;
            end
        end
        else if (exc_return)
        begin
            iset_d = stacked_status_word[`ISET_BIT];
            exc_d = ret_ok ? stacked_status_word[`EXC_MSB:`EXC_LSB] : `EXC_THREAD;
            if (ret_to_cont)
            begin
                st_d = ST_CONT;
                cont_d = cb_stacked[7:4];
            end
            else if (ret_to_block)
            begin
                st_d = ST_BLOCK;
                cb_d = cb_stacked;
            end
            else
                st_d = ST_IDLE;
        end
        else
        begin
            if (branch_any)
                iset_d = branch_target[0];
            case (st_q)
                ST_IDLE:
                begin
                    if (cb_start && cb_init[3:0] != 4'H0)
                    begin
                        st_d = ST_BLOCK;
                        cb_d = {cb_init[7:4], cb_init[3:0]};
                    end
                end
                ST_BLOCK:
                begin
                    if (cb_advance)
                    begin
                        cb_d = cb_next;
                        if (cb_next == 8'H00)
                            st_d = ST_IDLE;
                    end
                end
                ST_CONT:
                begin
                    if (mt_resume)
                    begin
                        st_d = ST_IDLE;
                        cont_d = 4'H0;
                    end
                end
                default:
                    st_d = ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= ST_IDLE;
            cb_q <= 8'H00;
            cont_q <= 4'H0;
            iset_q <= `ISET_RESET;
            exc_q <= `EXC_THREAD;
        end
        else
        begin
            st_q <= st_d;
            cb_q <= cb_d;
            cont_q <= cont_d;
            iset_q <= iset_d;
            exc_q <= exc_d;
        end
    end

    // ----------------------------------------------------------------
    // Saturation flag
    // ----------------------------------------------------------------
    // Set wins over a clearing write in the same cycle
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            sat_q <= 1'B0;
        else if (sat_event)
            sat_q <= 1'B1;
        else if (sat_clear)
            sat_q <= 1'B0;
    end

    // Same priority, taken early so the word shows it after this edge
    reg sat_n;
    always @*
    begin
        sat_n = sat_q;
        if (sat_event)
            sat_n = 1'B1;
        else if (sat_clear)
            sat_n = 1'B0;
    end

    // ----------------------------------------------------------------
    // Status word
    // ----------------------------------------------------------------
    // Built from next values so the word matches the state after this edge
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            program_status_word <= `PSW_RESET;
        else
            program_status_word <= build_word(sat_n, iset_d, pack_field(st_d, cb_d, cont_d),
                                              exc_d);
    end

    // ----------------------------------------------------------------
    // Software read port
    // ----------------------------------------------------------------
    // Execution fields never visible to software reads
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            sw_read_data <= 32'H0000_0000;
        else if (!view_reads_sat(sw_read_view))
            sw_read_data <= 32'H0000_0000;
        else if (view_reads_exc(sw_read_view))
            sw_read_data <= build_word(sat_q, 1'B0, 8'H00, exc_q);
        else
            sw_read_data <= build_word(sat_q, 1'B0, 8'H00, `EXC_THREAD);
    end

    // ----------------------------------------------------------------
    // Continuation resume
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mt_resume_reg <= 4'H0;
            mt_resume_valid <= 1'B0;
        end
        else
        begin
            mt_resume_valid <= (st_q == ST_CONT) && mt_resume;
            mt_resume_reg <= cont_q;
        end
    end

    // ----------------------------------------------------------------
    // State bit fault
    // ----------------------------------------------------------------
    // Flags the issue only; lockup handling sits outside this block
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            iset_fault <= 1'B0;
        else
            iset_fault <= instr_issue && !iset_q;
    end
endmodule

// ---- exec_status_checker.sv ----
`timescale 1ns/1ps
module exec_status_checker
(
    input wire ref_clk,
    input wire nrst,
    input wire sat_event,
    input wire sw_write,
    input wire [1:0] sw_write_view,
    input wire [31:0] sw_write_data,
    input wire [1:0] sw_read_view,
    input wire exc_entry,
    input wire [31:0] vector_value,
    input wire exc_return,
    input wire mt_interrupt,
    input wire [3:0] mt_next_reg,
    input wire instr_issue,
    input wire [31:0] program_status_word,
    input wire [31:0] sw_read_data,
    input wire iset_fault
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire [31:0] w = program_status_word;
    // ------------------------------------------------------------
    // Word, fault and read-port properties
    // ------------------------------------------------------------
    reserved_zero_a: assert property (w[23:16] == 8'H00 && w[9:6] == 4'H0)
        else $error("reserved bits not zero");
    sat_set_a: assert property (sat_event |=> w[27])
        else $error("saturation flag not set");
    sat_sticky_a: assert property (w[27] && !(sw_write && !sw_write_data[27] &&
        !sw_write_view[1]) |=> w[27]) else $error("saturation flag lost");
    iset_entry_a: assert property (exc_entry |=> w[24] == $past(vector_value[0]))
        else $error("state bit not loaded from vector");
    cont_save_a: assert property (exc_entry && mt_interrupt |=>
        w[15:10] == {$past(mt_next_reg), 2'H0} && w[26:25] == 2'H0)
        else $error("continuation field wrong");
    exc_ro_a: assert property (!exc_entry && !exc_return |=> $stable(w[5:0]))
        else $error("exception number changed");
    exc_legal_a: assert property (!(w[5:0] inside {6'H01, [6'H07:6'H0A],
        6'H0C, 6'H0D, [6'H3C:6'H3F]})) else $error("reserved exception number");
    fault_a: assert property (instr_issue && !w[24] |=> iset_fault)
        else $error("missing state fault");
    exec_read_a: assert property (sw_read_view == 2'H2 |=> sw_read_data == 32'H0)
        else $error("execution view read not zero");
endmodule
bind exec_exception_status exec_status_checker chk_u (.ref_clk, .nrst, .sat_event, .sw_write,
    .sw_write_view, .sw_write_data, .sw_read_view, .exc_entry, .vector_value, .exc_return,
    .mt_interrupt, .mt_next_reg, .instr_issue, .program_status_word, .sw_read_data, .iset_fault);

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    reg ref_clk = 1'B0, nrst = 1'B0, sat_event = 1'B0, sw_write = 1'B0, exc_entry = 1'B0;
    reg exc_return = 1'B0, branch_exchange = 1'B0, branch_link_exchange = 1'B0;
    reg pop_to_program_counter = 1'B0, cb_start = 1'B0, cb_advance = 1'B0;
    reg mt_interrupt = 1'B0, mt_resume = 1'B0, instr_issue = 1'B0;
    reg [1:0] sw_write_view = 2'H0, sw_read_view = 2'H0;
    reg [31:0] sw_write_data = 32'H0, vector_value = 32'H0, stacked_status_word = 32'H0;
    reg [31:0] branch_target = 32'H0, r, old;
    reg [5:0] exc_entry_num = 6'H00, exc_m;
    reg [7:0] cb_init = 8'H00;
    reg [3:0] mt_next_reg = 4'H0;
    reg sat_m, iset_m;
    reg [4:0] resume_q[$];
    wire [31:0] program_status_word, sw_read_data;
    wire [3:0] mt_resume_reg;
    wire mt_resume_valid, iset_fault;
    wire [7:0] field = {program_status_word[15:10], program_status_word[26:25]};
    integer miscompares = 0, samples_checked = 0, cycles = 0, i, k;
    exec_exception_status dut_u (.ref_clk, .nrst, .sat_event, .sw_write, .sw_write_view,
        .sw_write_data, .sw_read_view, .exc_entry, .exc_entry_num, .vector_value, .exc_return,
        .stacked_status_word, .branch_exchange, .branch_link_exchange, .pop_to_program_counter,
        .branch_target, .cb_start, .cb_init, .cb_advance, .mt_interrupt, .mt_next_reg,
        .mt_resume, .instr_issue, .program_status_word, .sw_read_data, .mt_resume_reg,
        .mt_resume_valid, .iset_fault);
    always #4 ref_clk = ~ref_clk;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function legal(input [5:0] n);
        legal = n == 0 || (n >= 2 && n <= 6) || n == 11 || n == 14 || n == 15 ||
            (n >= 16 && n <= 59);
    endfunction
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input string what, input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp)
            begin
                miscompares = miscompares + 1;
                $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // Pulses drop at the falling edge so each one is sampled exactly once
    task tick;
        begin
            @(posedge ref_clk);
            @(negedge ref_clk);
            {sat_event, sw_write, exc_entry, exc_return, branch_exchange, cb_start} = 6'H00;
            {branch_link_exchange, pop_to_program_counter, cb_advance} = 3'H0;
            {mt_interrupt, mt_resume, instr_issue} = 3'H0;
        end
    endtask
    // Far above the roughly 140 cycles the sequence needs
    always @(posedge ref_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 2000)
        begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        r = $urandom(99718);
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        nrst = 1'B1;
        chk("reset", program_status_word, 32'H01000000);
        {sat_m, iset_m, exc_m} = 8'H40;
        for (i = 0; i < 64; i = i + 1)
        begin
            r = $urandom;
            {exc_entry, exc_entry_num, vector_value} = {1'B1, i[5:0], r};
            {mt_interrupt, mt_next_reg} = r[8:4];
            iset_m = r[0];
            if (legal(i[5:0]))
                exc_m = i[5:0];
            tick;
            chk("exc_num", program_status_word[5:0], exc_m);
            chk("iset", program_status_word[24], iset_m);
            if (r[8])
                chk("cont", field, {r[7:4], 4'H0});
        end
        for (i = 0; i < 8; i = i + 1)
        begin
            r = $urandom;
            if (i == 0)
                r[5:0] = 6'H07;
            if (i == 7)
                {r[15:10], r[26:25]} = 8'H90;
            {exc_return, stacked_status_word} = {1'B1, r};
            exc_m = legal(r[5:0]) ? r[5:0] : 6'H00;
            if (i == 7)
                resume_q.push_back({1'B1, r[15:12]});
            tick;
            chk("ret_exc", program_status_word[5:0], exc_m);
            chk("ret_iset", program_status_word[24], r[24]);
            chk("ret_field", field, {r[15:10], r[26:25]});
        end
        mt_resume = 1'B1;
        tick;
        chk("resume", {mt_resume_valid, mt_resume_reg}, resume_q.pop_front());
        for (i = 0; i < 6; i = i + 1)
        begin
            {branch_exchange, branch_link_exchange, pop_to_program_counter} = 3'H1 << (i % 3);
            branch_target = ($urandom & 32'HFFFFFFFE) | (i >= 3);
            tick;
            chk("branch", program_status_word[24], i >= 3);
            instr_issue = 1'B1;
            tick;
            chk("fault", iset_fault, i < 3);
        end
        for (i = 0; i < 24; i = i + 1)
        begin
            r = $urandom;
            {sat_event, sw_write, sw_write_view} = r[3:0];
            sw_write_data = $urandom;
            old = program_status_word;
            if (r[2] && !sw_write_data[27] && !r[1])
                sat_m = 1'B0;
            if (r[3])
                sat_m = 1'B1;
            tick;
            chk("sat", program_status_word[27], sat_m);
            chk("ro_bits", program_status_word & 32'HF7FFFFFF, old & 32'HF7FFFFFF);
        end
        for (i = 0; i < 8; i = i + 1)
        begin
            {sw_read_view, sat_event, sw_write, sw_write_view} = {i[1:0], i < 4, i >= 4, 2'H1};
            sw_write_data = 32'H0;
            sat_m = i < 4;
            tick;
            tick;
            r = {4'H0, sat_m, 27'H0} | ((i % 2) ? exc_m : 6'H00);
            chk("read", sw_read_data, (i % 4 == 2) ? 32'H0 : r);
        end
        for (i = 0; i < 2; i = i + 1)
        begin
            {cb_start, cb_init} = {1'B1, i ? 8'HA1 : 8'H58};
            tick;
            chk("cb_init", field, i ? 8'HA1 : 8'H58);
            for (k = 0; k < (i ? 4 : 1); k = k + 1)
            begin
                cb_advance = 1'B1;
                tick;
                chk("cb_left", field == 8'H00, k == (i ? 3 : 0));
                if (i && k < 3)
                    chk("cb_cond", field[7:5], 3'H5);
            end
        end
        give_verdict;
    end
endmodule
